// *** rtl/jnp_col_mem.sv ***
// Column-organised non-volatile array model: one write port, bulk clear
// under a bit mask, read data registered.
// Assumes contents are undefined until the first erase after power-up.
module jnp_col_mem #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4,
   parameter int AW    = 2
) (
   // Clocking
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic             ce,
   // Access
   input  wire logic [AW-1:0]    addr,
   input  wire logic             wrEn,
   input  wire logic [WIDTH-1:0] wrData,
   input  wire logic             clrEn,
   input  wire logic [WIDTH-1:0] clrMask,
   output logic      [WIDTH-1:0] rdData
);
   logic [WIDTH-1:0] mem [DEPTH];

   always_ff @(posedge clk)
   begin
      if (ce && clrEn)
      begin
         for (int i = 0; i < DEPTH; i++)
         begin
            mem[i] <= mem[i] & ~clrMask;
         end
      end
      else if (ce && wrEn && (int'(addr) < DEPTH))
      begin
         mem[addr] <= wrData;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         rdData <= '0;
      end
      else if (ce)
      begin
         rdData <= (int'(addr) < DEPTH) ? mem[addr] : '0;
      end
   end
endmodule : jnp_col_mem

// *** rtl/jnp_pkg.sv ***
// Constants, instruction codes, carrier types and decode helpers for the
// test-port controller of the non-volatile program memories.
// Assumes a single system clock; test-port pins arrive asynchronously.
// Summary of operation
// - Array address load sets column, forces safe
// - Array column data shifts, outputs held safe
// - Array erases act on second idle edge
// - Column program writes data on second edge
// - Fuse program blocks later pattern readout
// - Column read loads data register for shifting
// - Discharge drops programming supply, outputs safe
// - Config address load sets column, forces safe
// - Config data register shifts, outputs safe
// - Config erase on second edge, program mode
// - Config program writes column on second edge
// - Config read loads data register, outputs safe
// - Full erase clears every non-volatile bit
// - Safe output acts after instruction update
// - Program enable sets mode, forces safe
// - Program disable or reset clears mode
// - Identification register shifts out on TDO
// - Status captures twelve monitor outputs
// - Signature erase only in program mode
// - Signature shift loads stored bits, connects
// - Signature program writes register in mode
// - Instruction register is six bits wide
// - Array address 75 bits, data 81
// - Config address 4 bits, data 41
// - External test and 1xxxxx select bypass
package jnp_pkg;
   localparam int IR_W       = 6;
   localparam int ARR_ADDR_W = 75;
   localparam int ARR_DATA_W = 81;
   localparam int ARR_IDX_W  = 7;
   localparam int CFG_ADDR_W = 4;
   localparam int CFG_DATA_W = 41;
   localparam int ID_W       = 32;
   localparam int MON_W      = 12;
   localparam int SIG_W      = 16;

   localparam logic [5:0] IR_CAPTURE_VALUE = 6'h01;
   localparam logic [1:0] RTI_FIRE_COUNT   = 2'h1;

   localparam logic [5:0] OP_EXTERNAL_TEST       = 6'h00;
   localparam logic [5:0] OP_ARRAY_ADDRESS_LOAD  = 6'h01;
   localparam logic [5:0] OP_ARRAY_COLUMN_DATA   = 6'h02;
   localparam logic [5:0] OP_AND_ARRAY_ERASE     = 6'h03;
   localparam logic [5:0] OP_ARCH_ARRAY_ERASE    = 6'h04;
   localparam logic [5:0] OP_ARRAY_COLUMN_PROG   = 6'h05;
   localparam logic [5:0] OP_SECURITY_FUSE_PROG  = 6'h06;
   localparam logic [5:0] OP_BYPASS              = 6'h07;
   localparam logic [5:0] OP_ARRAY_COLUMN_READ   = 6'h08;
   localparam logic [5:0] OP_DISCHARGE           = 6'h09;
   localparam logic [5:0] OP_CONFIG_ADDRESS_LOAD = 6'h0a;
   localparam logic [5:0] OP_CONFIG_DATA_SHIFT   = 6'h0b;
   localparam logic [5:0] OP_CONFIG_ERASE        = 6'h0c;
   localparam logic [5:0] OP_CONFIG_PROGRAM      = 6'h0d;
   localparam logic [5:0] OP_CONFIG_READ         = 6'h0e;
   localparam logic [5:0] OP_FULL_BULK_ERASE     = 6'h16;
   localparam logic [5:0] OP_SAFE_OUTPUT         = 6'h17;
   localparam logic [5:0] OP_PROGRAM_ENABLE      = 6'h18;
   localparam logic [5:0] OP_IDCODE              = 6'h19;
   localparam logic [5:0] OP_PROGRAM_DISABLE     = 6'h1a;
   localparam logic [5:0] OP_MONITOR_STATUS_SEL  = 6'h1b;
   localparam logic [5:0] OP_SAMPLE              = 6'h1c;
   localparam logic [5:0] OP_SIGNATURE_ERASE     = 6'h1d;
   localparam logic [5:0] OP_SIGNATURE_SHIFT     = 6'h1e;
   localparam logic [5:0] OP_SIGNATURE_PROGRAM   = 6'h1f;

   typedef enum logic [15:0] {
      TAP_RESET   = 16'h0001, TAP_IDLE    = 16'h0002, TAP_SEL_DR  = 16'h0004,
      TAP_CAP_DR  = 16'h0008, TAP_SH_DR   = 16'h0010, TAP_EX1_DR  = 16'h0020,
      TAP_PAU_DR  = 16'h0040, TAP_EX2_DR  = 16'h0080, TAP_UPD_DR  = 16'h0100,
      TAP_SEL_IR  = 16'h0200, TAP_CAP_IR  = 16'h0400, TAP_SH_IR   = 16'h0800,
      TAP_EX1_IR  = 16'h1000, TAP_PAU_IR  = 16'h2000, TAP_EX2_IR  = 16'h4000,
      TAP_UPD_IR  = 16'h8000
   } jnp_tap_e;

   typedef enum logic [7:0] {
      DR_BYPASS = 8'h01, DR_ARR_ADDR = 8'h02, DR_COLUMN = 8'h04, DR_CFG_ADDR = 8'h08,
      DR_CFG_DATA = 8'h10, DR_ID = 8'h20, DR_STATUS = 8'h40, DR_SIG = 8'h80
   } jnp_dr_e;

   typedef struct packed {
      logic tck;
      logic tms;
      logic tdi;
   } jnp_pins_s;

   typedef struct packed {
      logic tdo;
      logic tdoEn;
   } jnp_tdo_s;

   typedef struct packed {
      logic safeOutput;
      logic progMode;
      logic readoutProtect;
      logic vppCharged;
   } jnp_ctl_s;

   function automatic jnp_tap_e jnp_tap_next(input jnp_tap_e s, input logic tms);
      unique case (s)
         TAP_RESET:  return tms ? TAP_RESET  : TAP_IDLE;
         TAP_IDLE:   return tms ? TAP_SEL_DR : TAP_IDLE;
         TAP_SEL_DR: return tms ? TAP_SEL_IR : TAP_CAP_DR;
         TAP_CAP_DR: return tms ? TAP_EX1_DR : TAP_SH_DR;
         TAP_SH_DR:  return tms ? TAP_EX1_DR : TAP_SH_DR;
         TAP_EX1_DR: return tms ? TAP_UPD_DR : TAP_PAU_DR;
         TAP_PAU_DR: return tms ? TAP_EX2_DR : TAP_PAU_DR;
         TAP_EX2_DR: return tms ? TAP_UPD_DR : TAP_SH_DR;
         TAP_UPD_DR: return tms ? TAP_SEL_DR : TAP_IDLE;
         TAP_SEL_IR: return tms ? TAP_RESET  : TAP_CAP_IR;
         TAP_CAP_IR: return tms ? TAP_EX1_IR : TAP_SH_IR;
         TAP_SH_IR:  return tms ? TAP_EX1_IR : TAP_SH_IR;
         TAP_EX1_IR: return tms ? TAP_UPD_IR : TAP_PAU_IR;
         TAP_PAU_IR: return tms ? TAP_EX2_IR : TAP_PAU_IR;
         TAP_EX2_IR: return tms ? TAP_UPD_IR : TAP_SH_IR;
         TAP_UPD_IR: return tms ? TAP_SEL_DR : TAP_IDLE;
         default:    return TAP_RESET;
      endcase
   endfunction : jnp_tap_next

   // Codes that hold the outputs in the safe state while current
   function automatic logic jnp_is_safe(input logic [5:0] op);
      unique case (op)
         6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h06, 6'h08, 6'h09, 6'h0a, 6'h0b,
         6'h0c, 6'h0d, 6'h0e, 6'h16, 6'h17, 6'h18, 6'h1d, 6'h1f: return 1'b1;
         default: return 1'b0;
      endcase
   endfunction : jnp_is_safe

   // Any code not naming a data register falls back to bypass
   function automatic jnp_dr_e jnp_dr_sel(input logic [5:0] op);
      unique case (op)
         OP_ARRAY_ADDRESS_LOAD:                       return DR_ARR_ADDR;
         OP_ARRAY_COLUMN_DATA, OP_ARRAY_COLUMN_READ:  return DR_COLUMN;
         OP_CONFIG_ADDRESS_LOAD:                      return DR_CFG_ADDR;
         OP_CONFIG_DATA_SHIFT, OP_CONFIG_READ:        return DR_CFG_DATA;
         OP_IDCODE:                                   return DR_ID;
         OP_MONITOR_STATUS_SEL:                       return DR_STATUS;
         OP_SIGNATURE_SHIFT:                          return DR_SIG;
         default:                                     return DR_BYPASS;
      endcase
   endfunction : jnp_dr_sel
endpackage : jnp_pkg

// *** rtl/jnp_program_ctrl.sv ***
// Test-port instruction logic for programming the logic array,
// configuration array, user signature and readout-protect fuse.
// Assumes the test clock is far slower than clk (at least 4 clk per half
// period); all pins are sampled through two flip-flops.
module jnp_program_ctrl
   import jnp_pkg::*;
#(
   parameter logic [31:0] ID_CODE  = 32'h0000_0001, // Arbitrary value
   parameter int          AND_BITS = 64,
   parameter int          ARR_COLS = 75,
   parameter int          CFG_COLS = 16
) (
   // Clocking
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic             ce,
   // Test port
   input  wire jnp_pkg::jnp_pins_s  pins,
   output jnp_pkg::jnp_tdo_s        tdoOut,
   // Monitor comparators
   input  wire logic [jnp_pkg::MON_W-1:0] voltageMonitor,
   // Device control
   output jnp_pkg::jnp_ctl_s        ctl,
   output logic [jnp_pkg::SIG_W-1:0] userSignature
);
   import jnp_pkg::*;

   localparam logic [ARR_DATA_W-1:0] AND_MASK = ~({ARR_DATA_W{1'b1}} << AND_BITS);

   typedef struct packed {
      jnp_tap_e                tap;
      logic                    prevTck;
      logic [IR_W-1:0]         ir;
      logic [IR_W-1:0]         irShift;
      logic [1:0]              rtiCnt;
      logic [ARR_ADDR_W-1:0]   arrAddr;
      logic [ARR_DATA_W-1:0]   colData;
      logic [CFG_ADDR_W-1:0]   cfgAddr;
      logic [CFG_DATA_W-1:0]   cfgData;
      logic [ID_W-1:0]         idShift;
      logic [MON_W-1:0]        status;
      logic [SIG_W-1:0]        sigShift;
      logic [SIG_W-1:0]        sigStore;
      logic                    bypass;
      logic                    progMode;
      logic                    safeOutput;
      logic                    protect;
      logic                    vppCharged;
      logic                    tdo;
      logic                    tdoEn;
      logic                    arrWr;
      logic                    arrClr;
      logic [ARR_DATA_W-1:0]   arrClrMask;
      logic                    cfgWr;
      logic                    cfgClr;
   } jnp_state_s;

   jnp_state_s              st;
   jnp_state_s              next_st;
   jnp_pins_s               pinS;
   logic [MON_W-1:0]        monS;
   logic [ARR_DATA_W-1:0]   arrRd;
   logic [CFG_DATA_W-1:0]   cfgRd;
   logic [ARR_IDX_W-1:0]    arrIdx;
   logic                    tckRise;
   logic                    tckFall;
   logic                    fire;
   jnp_dr_e                 drSel;

   jnp_sync #(.WIDTH(3)) u_pin_sync (
      .clk   (clk),
      .rst_n (rst_n),
      .ce    (ce),
      .din   (pins),
      .dout  (pinS)
   );

   jnp_sync #(.WIDTH(MON_W)) u_mon_sync (
      .clk   (clk),
      .rst_n (rst_n),
      .ce    (ce),
      .din   (voltageMonitor),
      .dout  (monS)
   );

   always_comb
   begin
      arrIdx = '0;
      for (int i = ARR_ADDR_W - 1; i >= 0; i--)
      begin
         if (st.arrAddr[i])
         begin
            arrIdx = ARR_IDX_W'(i);
         end
      end
   end

   jnp_col_mem #(.WIDTH(ARR_DATA_W), .DEPTH(ARR_COLS), .AW(ARR_IDX_W)) u_arr_mem (
      .clk     (clk),
      .rst_n   (rst_n),
      .ce      (ce),
      .addr    (arrIdx),
      .wrEn    (st.arrWr),
      .wrData  (st.colData),
      .clrEn   (st.arrClr),
      .clrMask (st.arrClrMask),
      .rdData  (arrRd)
   );

   jnp_col_mem #(.WIDTH(CFG_DATA_W), .DEPTH(CFG_COLS), .AW(CFG_ADDR_W)) u_cfg_mem (
      .clk     (clk),
      .rst_n   (rst_n),
      .ce      (ce),
      .addr    (st.cfgAddr),
      .wrEn    (st.cfgWr),
      .wrData  (st.cfgData),
      .clrEn   (st.cfgClr),
      .clrMask ({CFG_DATA_W{1'b1}}),
      .rdData  (cfgRd)
   );

   assign tckRise = ce && pinS.tck && !st.prevTck;
   assign tckFall = ce && !pinS.tck && st.prevTck;
   assign fire    = tckRise && (st.tap == TAP_IDLE) && (st.rtiCnt == RTI_FIRE_COUNT);
   assign drSel   = jnp_dr_sel(st.ir);

   always_comb
   begin
      next_st            = st;
      next_st.prevTck    = pinS.tck;
      next_st.arrWr      = 1'b0;
      next_st.arrClr     = 1'b0;
      next_st.cfgWr      = 1'b0;
      next_st.cfgClr     = 1'b0;

      if (tckRise)
      begin
         if (st.tap != TAP_IDLE)
         begin
            next_st.rtiCnt = 2'h0;
         end
         else if (st.rtiCnt != 2'h3)
         begin
            next_st.rtiCnt = st.rtiCnt + 2'h1;
         end

         unique case (st.tap)
            TAP_RESET:
            begin
               next_st.ir       = OP_IDCODE;
               next_st.progMode = 1'b0;
            end
            TAP_CAP_IR:
            begin
               next_st.irShift = IR_CAPTURE_VALUE;
            end
            TAP_SH_IR:
            begin
               next_st.irShift = {pins_tdi(pinS), st.irShift[IR_W-1:1]};
            end
            TAP_UPD_IR:
            begin
               next_st.ir = st.irShift;
               if (st.irShift == OP_PROGRAM_ENABLE)
               begin
                  next_st.progMode = 1'b1;
               end
               if (st.irShift == OP_PROGRAM_DISABLE)
               begin
                  next_st.progMode = 1'b0;
               end
               if (st.irShift == OP_DISCHARGE)
               begin
                  next_st.vppCharged = 1'b0;
               end
            end
            TAP_CAP_DR:
            begin
               unique case (st.ir)
                  OP_ARRAY_COLUMN_READ: next_st.colData  = st.protect ? '0 : arrRd;
                  OP_CONFIG_READ:       next_st.cfgData  = st.protect ? '0 : cfgRd;
                  OP_IDCODE:            next_st.idShift  = ID_CODE;
                  OP_MONITOR_STATUS_SEL: next_st.status  = monS;
                  OP_SIGNATURE_SHIFT:   next_st.sigShift = st.sigStore;
                  default:              next_st.bypass   = 1'b0;
               endcase
            end
            TAP_SH_DR:
            begin
               unique case (drSel)
                  DR_ARR_ADDR: next_st.arrAddr  = {pinS.tdi, st.arrAddr[ARR_ADDR_W-1:1]};
                  DR_COLUMN:   next_st.colData  = {pinS.tdi, st.colData[ARR_DATA_W-1:1]};
                  DR_CFG_ADDR: next_st.cfgAddr  = {pinS.tdi, st.cfgAddr[CFG_ADDR_W-1:1]};
                  DR_CFG_DATA: next_st.cfgData  = {pinS.tdi, st.cfgData[CFG_DATA_W-1:1]};
                  DR_ID:       next_st.idShift  = {pinS.tdi, st.idShift[ID_W-1:1]};
                  DR_STATUS:   next_st.status   = {pinS.tdi, st.status[MON_W-1:1]};
                  DR_SIG:      next_st.sigShift = {pinS.tdi, st.sigShift[SIG_W-1:1]};
                  DR_BYPASS:   next_st.bypass   = pinS.tdi;
               endcase
            end
            default:
            begin
            end
         endcase

         next_st.tap = jnp_tap_next(st.tap, pinS.tms);
      end

      if (fire && st.progMode)
      begin
         unique case (st.ir)
            OP_AND_ARRAY_ERASE:
            begin
               next_st.arrClr     = 1'b1;
               next_st.arrClrMask = AND_MASK;
               next_st.vppCharged = 1'b1;
            end
            OP_ARCH_ARRAY_ERASE:
            begin
               next_st.arrClr     = 1'b1;
               next_st.arrClrMask = ~AND_MASK;
               next_st.vppCharged = 1'b1;
            end
            OP_ARRAY_COLUMN_PROG:
            begin
               next_st.arrWr      = 1'b1;
               next_st.vppCharged = 1'b1;
            end
            OP_SECURITY_FUSE_PROG:
            begin
               next_st.protect    = 1'b1;
               next_st.vppCharged = 1'b1;
            end
            OP_CONFIG_ERASE:
            begin
               next_st.cfgClr     = 1'b1;
               next_st.vppCharged = 1'b1;
            end
            OP_CONFIG_PROGRAM:
            begin
               next_st.cfgWr      = 1'b1;
               next_st.vppCharged = 1'b1;
            end
            OP_FULL_BULK_ERASE:
            begin
               next_st.arrClr     = 1'b1;
               next_st.arrClrMask = {ARR_DATA_W{1'b1}};
               next_st.cfgClr     = 1'b1;
               next_st.sigStore   = '0;
               next_st.protect    = 1'b0;
               next_st.vppCharged = 1'b1;
            end
            OP_SIGNATURE_ERASE:
            begin
               next_st.sigStore   = '0;
               next_st.vppCharged = 1'b1;
            end
            OP_SIGNATURE_PROGRAM:
            begin
               next_st.sigStore   = st.sigShift;
               next_st.vppCharged = 1'b1;
            end
            default:
            begin
            end
         endcase
      end

      // Shifter moved on the rise, so the new bit is presented on the fall
      if (tckFall)
      begin
         next_st.tdoEn = (st.tap == TAP_SH_IR) || (st.tap == TAP_SH_DR);
         if (st.tap == TAP_SH_IR)
         begin
            next_st.tdo = st.irShift[0];
         end
         else
         begin
            unique case (drSel)
               DR_ARR_ADDR: next_st.tdo = st.arrAddr[0];
               DR_COLUMN:   next_st.tdo = st.colData[0];
               DR_CFG_ADDR: next_st.tdo = st.cfgAddr[0];
               DR_CFG_DATA: next_st.tdo = st.cfgData[0];
               DR_ID:       next_st.tdo = st.idShift[0];
               DR_STATUS:   next_st.tdo = st.status[0];
               DR_SIG:      next_st.tdo = st.sigShift[0];
               DR_BYPASS:   next_st.tdo = st.bypass;
            endcase
         end
      end

      next_st.safeOutput = jnp_is_safe(next_st.ir) || next_st.progMode;
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         st            <= '0;
         st.tap        <= TAP_RESET;
         st.ir         <= OP_IDCODE;
         st.arrClrMask <= '0;
      end
      else if (ce)
      begin
         st <= next_st;
      end
   end

   function automatic logic pins_tdi(input jnp_pins_s p);
      return p.tdi;
   endfunction : pins_tdi

   assign tdoOut        = '{tdo: st.tdo, tdoEn: st.tdoEn};
   assign ctl           = '{safeOutput: st.safeOutput, progMode: st.progMode,
                            readoutProtect: st.protect, vppCharged: st.vppCharged};
   assign userSignature = st.sigStore;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence s_upd_ir(logic [5:0] op);
      tckRise && (st.tap == TAP_UPD_IR) && (st.irShift == op);
   endsequence

   sequence s_cap_dr(logic [5:0] op);
      tckRise && (st.tap == TAP_CAP_DR) && (st.ir == op);
   endsequence

   safe_after_update_a: assert property (
      s_upd_ir(OP_SAFE_OUTPUT) |=> st.safeOutput && (st.ir == OP_SAFE_OUTPUT))
      else $error("safe output not active after instruction update");

   prog_enable_sets_a: assert property (
      s_upd_ir(OP_PROGRAM_ENABLE) |=> st.progMode && st.safeOutput)
      else $error("program enable did not set mode and safe output");

   reset_clears_mode_a: assert property (
      tckRise && (st.tap == TAP_RESET) |=> !st.progMode && (st.ir == OP_IDCODE))
      else $error("test logic reset left program mode set");

   write_needs_mode_a: assert property (
      (st.arrWr || st.arrClr || st.cfgWr || st.cfgClr) |-> st.progMode)
      else $error("memory changed outside program mode");

   column_prog_edge_a: assert property (
      fire && st.progMode && (st.ir == OP_ARRAY_COLUMN_PROG)
         |=> st.arrWr ##1 !st.arrWr)
      else $error("column program pulse not one cycle at second idle edge");

   status_capture_a: assert property (
      s_cap_dr(OP_MONITOR_STATUS_SEL) |=> st.status == $past(monS))
      else $error("status did not capture monitor outputs");

   protect_read_a: assert property (
      s_cap_dr(OP_ARRAY_COLUMN_READ) && st.protect |=> st.colData == '0)
      else $error("protected array column was read out");

   bypass_capture_a: assert property (
      tckRise && (st.tap == TAP_CAP_DR) && st.ir[5] |=> !st.bypass)
      else $error("bypass bit not captured as zero");

   ir_capture_a: assert property (
      tckRise && (st.tap == TAP_CAP_IR) |=> st.irShift == IR_CAPTURE_VALUE)
      else $error("instruction capture value wrong");

   tdo_enable_a: assert property (
      tckFall && (st.tap == TAP_SH_DR) && (st.ir == OP_IDCODE)
         |=> st.tdoEn && (st.tdo == $past(st.idShift[0])))
      else $error("identification bit not driven on TDO");
endmodule : jnp_program_ctrl

// *** rtl/jnp_sync.sv ***
// Two-stage synchroniser for a bundle of asynchronous levels.
// Assumes each bit is a slow level; no bus coherency between bits.
module jnp_sync #(
   parameter int WIDTH = 1
) (
   // Clocking
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic             ce,
   // Levels
   input  wire logic [WIDTH-1:0] din,
   output logic      [WIDTH-1:0] dout
);
   logic [WIDTH-1:0] meta;

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         meta <= '0;
         dout <= '0;
      end
      else if (ce)
      begin
         meta <= din;
         dout <= meta;
      end
   end
endmodule : jnp_sync

// *** tb/jnp_tap_master.sv ***
// Test-port programmer model: drives the three pins, reads tdo.
// Assumes a test clock half period of four system clocks.
module jnp_tap_master
   import jnp_pkg::*;
(
   // Clocking
   input  wire logic          clk,
   // Test port
   output jnp_pkg::jnp_pins_s pins,
   input  wire logic          tdo
);
   timeunit 1ns;
   timeprecision 1ns;
   initial pins = '0;
   // Tdo taken at the end of the low half, before the rise
   // Called just after a clk edge; four clk low, four high keeps 320 ns
   task automatic step(input logic ms, input logic di, output logic dout);
      pins <= '{tck: 1'b0, tms: ms, tdi: di};
      repeat (4) @(posedge clk);
      dout = tdo;
      pins.tck <= 1'b1;
      repeat (4) @(posedge clk);
   endtask : step
   // IR or DR scans of n bits, LSB first, ending in Idle
   task automatic scan(input logic ir, input int n, input logic [80:0] din,
                       output logic [80:0] dout);
      logic b;
      step(1'b1, 1'b0, b);
      if (ir)
         step(1'b1, 1'b0, b);
      step(1'b0, 1'b0, b);
      step(1'b0, 1'b0, b);
      for (int i = 0; i < n; i++)
      begin
         step(i == n - 1, din[i], b);
         dout[i] = b;
      end
      step(1'b1, 1'b0, b);
      step(1'b0, 1'b0, b);
   endtask : scan
   task automatic idle(input int n);
      logic b;
      repeat (n) step(1'b0, 1'b0, b);
   endtask : idle
endmodule : jnp_tap_master

// *** tb/testbench.sv ***
// Self-checking bench for the test-port program controller.
// Assumes the partner model owns every test-port pin.
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   import jnp_pkg::*;
   localparam logic [31:0] ID = 32'h1357_9bdf; // Arbitrary value
   localparam logic [80:0] COL = 81'h123456789abcdef012345;
   localparam logic [40:0] CFG = 41'h15a3c96e70f;
   logic             clk   = 1'b0;
   logic             rst_n = 1'b0;
   logic [MON_W-1:0] mon   = 12'h000;
   jnp_pins_s        pins;
   jnp_tdo_s         tdoOut;
   jnp_ctl_s         ctl;
   logic [SIG_W-1:0] sig;
   logic [80:0]      got;
   int               fails;
   int               num_checks;
   initial forever #20 clk = ~clk;
   jnp_program_ctrl #(.ID_CODE(ID)) dut (.clk(clk), .rst_n(rst_n), .ce(1'b1), .pins(pins),
      .tdoOut(tdoOut), .voltageMonitor(mon), .ctl(ctl), .userSignature(sig));
   jnp_tap_master m (.clk(clk), .pins(pins), .tdo(tdoOut.tdo));
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         fails++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic close_out();
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : close_out
   task automatic ir(input logic [5:0] op);
      m.scan(1'b1, 6, {75'h0, op}, got);
   endtask : ir
   task automatic testIdcode();
      check("ctl", ctl, 4'h0);
      m.idle(1);
      ir(6'h19);
      check("ir", got[5:0], 6'h01);
      m.scan(1'b0, 32, 81'h0, got);
      check("id", got[31:0], ID);
   endtask : testIdcode
   task automatic testBypass();
      logic [5:0] codes [3] = '{6'h00, 6'h20, 6'h3f};
      foreach (codes[i])
      begin
         ir(codes[i]);
         m.scan(1'b0, 2, 81'h1, got);
         check("bypass", got[1:0], 2'h2);
      end
   endtask : testBypass
   task automatic testStatus();
      @(posedge clk) mon <= 12'ha5c;
      ir(6'h1b);
      m.scan(1'b0, 12, 81'h0, got);
      check("status", got[11:0], 12'ha5c);
   endtask : testStatus
   task automatic testSafe();
      logic [5:0] codes [3] = '{6'h17, 6'h01, 6'h0b};
      foreach (codes[i])
      begin
         ir(codes[i]);
         check("safe", ctl.safeOutput, 1'b1);
      end
      ir(6'h19);
      check("unsafe", ctl.safeOutput, 1'b0);
   endtask : testSafe
   task automatic testSignature();
      ir(6'h1e);
      m.scan(1'b0, 16, 81'h5a3c, got);
      check("stored", got[15:0], 16'h0000);
      ir(6'h1f);
      m.idle(3);
      check("unarmed", sig, 16'h0000);
      ir(6'h18);
      check("mode", {ctl.progMode, ctl.safeOutput}, 2'h3);
      ir(6'h1d);
      m.idle(3);
      ir(6'h1f);
      m.idle(3);
      check("written", sig, 16'h5a3c);
      ir(6'h1e);
      m.scan(1'b0, 16, 81'h0, got);
      check("readback", got[15:0], 16'h5a3c);
      ir(6'h1a);
      check("mode off", ctl.progMode, 1'b0);
   endtask : testSignature
   task automatic testArrays();
      ir(6'h18);
      ir(6'h16);
      m.idle(3);
      check("erased", sig, 16'h0000);
      check("charged", ctl.vppCharged, 1'b1);
      ir(6'h01);
      m.scan(1'b0, 75, 81'h4, got);
      ir(6'h02);
      m.scan(1'b0, 81, COL, got);
      ir(6'h05);
      m.idle(3);
      ir(6'h09);
      check("discharged", ctl.vppCharged, 1'b0);
      // Second read shows the capture, not leftover shift data
      ir(6'h08);
      repeat (2) m.scan(1'b0, 81, 81'h0, got);
      check("col lo", got[31:0], COL[31:0]);
      check("col mid", got[63:32], COL[63:32]);
      check("col hi", got[80:64], COL[80:64]);
      ir(6'h0a);
      m.scan(1'b0, 4, 81'h3, got);
      ir(6'h0b);
      m.scan(1'b0, 41, {40'h0, CFG}, got);
      ir(6'h0d);
      m.idle(3);
      ir(6'h0e);
      repeat (2) m.scan(1'b0, 41, 81'h0, got);
      check("cfg lo", got[31:0], CFG[31:0]);
      check("cfg hi", got[40:32], CFG[40:32]);
      ir(6'h06);
      m.idle(3);
      check("fuse", ctl.readoutProtect, 1'b1);
      ir(6'h08);
      m.scan(1'b0, 81, 81'h0, got);
      check("protected", got[31:0], 32'h0);
      ir(6'h1a);
   endtask : testArrays
   initial
   begin
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      testIdcode();
      testBypass();
      testStatus();
      testSafe();
      testSignature();
      testArrays();
      close_out();
   end
   // Whole run is near 0.35 ms; limit allows about three times that
   initial
   begin
      #1ms;
      fails++;
      close_out();
   end
endmodule : testbench
